// >>> hdl/overtemp_alert_status_mask.sv
`timescale 1ns/1ps
`include "fan_monitor_cfg.svh"
// Operation
// - A channel 1 fault at a measurement sets status bit 7.
// - A channel 2 fault at a measurement sets status bit 6.
// - The status register is cleared only by reading it.
// - Reading status releases the alert pin to high impedance.
// - A fault still present at the next measurement sets status and alert again.
// - Status reads zero after reset.
// - Mask bit 7 set keeps channel 1 faults off the alert pin.
// - Mask bit 6 set keeps channel 2 faults off the alert pin.
// - The mask reads zero after reset, both channels unmasked.
// - The five pin level bits start from the five strap inputs.
// - An over-limit unmasked channel drives the alert pin low.
module overtemp_alert_status_mask #(
    parameter logic [7:0] REVISION_VALUE = 8'h11,
    parameter logic [7:0] PART_VALUE = 8'h22,
    parameter logic [7:0] VENDOR_VALUE = 8'h33,
    parameter int PIN_COUNT = 5
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:2] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    input wire logic meas_done_i,
    input wire logic ch1_over_i,
    input wire logic ch2_over_i,
    input wire fan_monitor_pkg::reg_byte_t pwm2_duty_now_i,
    output logic overtemp_alert_out_n_o,
    output logic overtemp_alert_out_n_oe_o,
    input wire fan_monitor_pkg::pin_vec_t pin_power_up_strap_i,
    input wire fan_monitor_pkg::pin_vec_t general_pin_bit_i,
    output fan_monitor_pkg::pin_vec_t general_pin_bit_o,
    output fan_monitor_pkg::pin_vec_t general_pin_bit_oe_o,
    output fan_monitor_pkg::reg_byte_t ch1_fan_start_temp_o,
    output fan_monitor_pkg::reg_byte_t ch2_fan_start_temp_o,
    output fan_monitor_pkg::reg_byte_t fan_setup_o,
    output fan_monitor_pkg::reg_byte_t duty_slew_rate_o,
    output fan_monitor_pkg::reg_byte_t duty_step_size_o,
    output logic [2:0] pwm_freq_select_o
);
    import fan_monitor_pkg::*;

    // The pin logic is written for exactly five pins, so refuse any other count.
    if (PIN_COUNT != 5) begin : g_bad_pin_count
        $error("PIN_COUNT must be 5");
    end

    logic rd_stb;
    logic wr_stb;
    reg_byte_t idx;
    reg_byte_t wdata;
    logic lane0;
    reg_byte_t overtemp_flags;
    reg_byte_t overtemp_alert_mask;
    reg_byte_t ch1_fan_start_temp;
    reg_byte_t ch2_fan_start_temp;
    reg_byte_t fan_setup;
    reg_byte_t duty_slew_rate;
    reg_byte_t duty_step_size;
    reg_byte_t pwm_freq_select;
    reg_byte_t pin_direction;
    reg_byte_t pin_level;
    logic [`EVENT_BITS-1:0] event_status;
    logic [`EVENT_BITS-1:0] event_enable;
    logic [`EVENT_BITS-1:0] next_events;
    logic alert_active;
    logic alert_seen;
    logic ch1_set;
    logic ch2_set;
    logic flags_read;
    logic strap_pending;
    reg_byte_t next_rdata;

    function automatic logic write_hit(input reg_byte_t reg_idx);
        write_hit = wr_stb && lane0 && (idx == reg_idx);
    endfunction

    assign wdata = dat_i[7:0];
    assign lane0 = sel_i[0];

    wb_reg_port bus_port (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .adr_i(adr_i),
        .ack_o(ack_o),
        .rd_stb_o(rd_stb),
        .wr_stb_o(wr_stb),
        .idx_o(idx)
    );

    // Only a read clears the flags; a write to this index is dropped.
    assign flags_read = rd_stb && (idx == `IDX_OVERTEMP_FLAGS);

    overtemp_flag_unit flag_unit (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .meas_done_i(meas_done_i),
        .ch1_over_i(ch1_over_i),
        .ch2_over_i(ch2_over_i),
        .flags_read_i(flags_read),
        .alert_mask_i(overtemp_alert_mask),
        .flags_o(overtemp_flags),
        .alert_active_o(alert_active),
        .ch1_set_o(ch1_set),
        .ch2_set_o(ch2_set)
    );

    // Open-drain alert: the pin only ever pulls low; released means enable off.
    assign overtemp_alert_out_n_o = 1'b0;
    assign overtemp_alert_out_n_oe_o = alert_active;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overtemp_alert_mask <= `RST_OVERTEMP_ALERT_MASK;
        end else if (write_hit(`IDX_OVERTEMP_ALERT_MASK)) begin
            overtemp_alert_mask <= wdata & `FLAGS_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ch1_fan_start_temp <= `RST_FAN_START_TEMP;
            ch2_fan_start_temp <= `RST_FAN_START_TEMP;
        end else begin
            if (write_hit(`IDX_CH1_FAN_START_TEMP)) begin
                ch1_fan_start_temp <= wdata;
            end
            if (write_hit(`IDX_CH2_FAN_START_TEMP)) begin
                ch2_fan_start_temp <= wdata;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fan_setup <= `RST_FAN_SETUP;
            duty_slew_rate <= `RST_DUTY_SLEW_RATE;
            duty_step_size <= `RST_DUTY_STEP_SIZE;
            pwm_freq_select <= `RST_PWM_FREQ_SELECT;
        end else begin
            if (write_hit(`IDX_FAN_SETUP)) begin
                fan_setup <= wdata;
            end
            if (write_hit(`IDX_DUTY_SLEW_RATE)) begin
                duty_slew_rate <= wdata;
            end
            if (write_hit(`IDX_DUTY_STEP_SIZE)) begin
                duty_step_size <= wdata;
            end
            if (write_hit(`IDX_PWM_FREQ_SELECT)) begin
                pwm_freq_select <= wdata & `FREQ_SELECT_MASK;
            end
        end
    end

    assign ch1_fan_start_temp_o = ch1_fan_start_temp;
    assign ch2_fan_start_temp_o = ch2_fan_start_temp;
    assign fan_setup_o = fan_setup;
    assign duty_slew_rate_o = duty_slew_rate;
    assign duty_step_size_o = duty_step_size;
    assign pwm_freq_select_o = pwm_freq_select[7:5];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_direction <= `RST_PIN_DIRECTION;
        end else if (write_hit(`IDX_PIN_DIRECTION)) begin
            pin_direction <= wdata & `PIN_MASK;
        end
    end

    // The strap level is caught on the first edge after reset, not inside reset,
    // so the reset branch stays constant.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_pending <= 1'b1;
        end else begin
            strap_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_level <= 8'h00;
        end else if (strap_pending) begin
            pin_level <= {3'h0, pin_power_up_strap_i};
        end else if (write_hit(`IDX_PIN_LEVEL)) begin
            pin_level <= wdata & `PIN_MASK;
        end
    end

    // Direction bit zero means output, so the enable is its inverse.
    assign general_pin_bit_o = pin_level[4:0];
    assign general_pin_bit_oe_o = ~pin_direction[4:0];

    // Events: each channel setting its fault, and the alert pin newly asserting.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alert_seen <= 1'b0;
        end else begin
            alert_seen <= alert_active;
        end
    end

    always_comb begin
        next_events = '0;
        next_events[`EVT_CH1] = ch1_set;
        next_events[`EVT_CH2] = ch2_set;
        next_events[`EVT_ALERT] = alert_active && !alert_seen;
    end

    // A new event outranks a write-one-to-clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_status <= `RST_EVENT;
        end else if (write_hit(`IDX_EVENT_STATUS)) begin
            event_status <= (event_status & ~wdata[`EVENT_BITS-1:0]) | next_events;
        end else begin
            event_status <= event_status | next_events;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_enable <= `RST_EVENT;
        end else if (write_hit(`IDX_EVENT_ENABLE)) begin
            event_enable <= wdata[`EVENT_BITS-1:0];
        end
    end

    assign irq_o = |(event_status & event_enable);

    // Read-only and unmapped indices have no write branch anywhere above.
    always_comb begin
        next_rdata = 8'h00;
        if (idx == `IDX_OVERTEMP_FLAGS) begin
            next_rdata = overtemp_flags;
        end else if (idx == `IDX_OVERTEMP_ALERT_MASK) begin
            next_rdata = overtemp_alert_mask;
        end else if (idx == `IDX_PWM2_DUTY_NOW) begin
            next_rdata = pwm2_duty_now_i;
        end else if (idx == `IDX_CH1_FAN_START_TEMP) begin
            next_rdata = ch1_fan_start_temp;
        end else if (idx == `IDX_CH2_FAN_START_TEMP) begin
            next_rdata = ch2_fan_start_temp;
        end else if (idx == `IDX_FAN_SETUP) begin
            next_rdata = fan_setup;
        end else if (idx == `IDX_DUTY_SLEW_RATE) begin
            next_rdata = duty_slew_rate;
        end else if (idx == `IDX_DUTY_STEP_SIZE) begin
            next_rdata = duty_step_size;
        end else if (idx == `IDX_PWM_FREQ_SELECT) begin
            next_rdata = pwm_freq_select;
        end else if (idx == `IDX_PIN_DIRECTION) begin
            next_rdata = pin_direction;
        end else if (idx == `IDX_PIN_LEVEL) begin
            // Input pins read their live level, output pins the stored value.
            next_rdata = {3'h0, (general_pin_bit_i & pin_direction[4:0])
                | (pin_level[4:0] & ~pin_direction[4:0])};
        end else if (idx == `IDX_EVENT_STATUS) begin
            next_rdata = {5'h00, event_status};
        end else if (idx == `IDX_EVENT_ENABLE) begin
            next_rdata = {5'h00, event_enable};
        end else if (idx == `IDX_SILICON_REVISION) begin
            next_rdata = REVISION_VALUE;
        end else if (idx == `IDX_PART_CODE) begin
            next_rdata = PART_VALUE;
        end else if (idx == `IDX_VENDOR_CODE) begin
            next_rdata = VENDOR_VALUE;
        end
    end

    // Data is captured on the same edge as a clearing read, so the old flags return.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (rd_stb) begin
            dat_o <= {24'h00_0000, next_rdata};
        end
    end

endmodule

// >>> hdl/fan_monitor_cfg.svh
`ifndef FAN_MONITOR_CFG_SVH
`define FAN_MONITOR_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_OVERTEMP_FLAGS 8'h05
`define IDX_OVERTEMP_ALERT_MASK 8'h06
`define IDX_PWM2_DUTY_NOW 8'h0e
`define IDX_CH1_FAN_START_TEMP 8'h0f
`define IDX_CH2_FAN_START_TEMP 8'h10
`define IDX_FAN_SETUP 8'h11
`define IDX_DUTY_SLEW_RATE 8'h12
`define IDX_DUTY_STEP_SIZE 8'h13
`define IDX_PWM_FREQ_SELECT 8'h14
`define IDX_PIN_DIRECTION 8'h15
`define IDX_PIN_LEVEL 8'h16
`define IDX_EVENT_STATUS 8'h20
`define IDX_EVENT_ENABLE 8'h21
`define IDX_SILICON_REVISION 8'hfd
`define IDX_PART_CODE 8'hfe
`define IDX_VENDOR_CODE 8'hff

// Field positions.
`define BIT_CH1_FAULT 7
`define BIT_CH2_FAULT 6
`define EVT_CH1 0
`define EVT_CH2 1
`define EVT_ALERT 2
`define EVENT_BITS 3

// Writable bits of the partly implemented registers.
`define FLAGS_MASK 8'hc0
`define FREQ_SELECT_MASK 8'he0
`define PIN_MASK 8'h1f

// Reset values.
`define RST_OVERTEMP_FLAGS 8'h00
`define RST_OVERTEMP_ALERT_MASK 8'h00
`define RST_FAN_START_TEMP 8'h00
`define RST_FAN_SETUP 8'h00
`define RST_DUTY_SLEW_RATE 8'hb4
`define RST_DUTY_STEP_SIZE 8'h55
`define RST_PWM_FREQ_SELECT 8'h40
`define RST_PIN_DIRECTION 8'h00
`define RST_EVENT 3'h0

`endif

// >>> hdl/fan_monitor_pkg.sv
package fan_monitor_pkg;

    typedef logic [7:0] reg_byte_t;
    typedef logic [4:0] pin_vec_t;

    // Gray order along idle, answer.
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ANSWER = 2'b01
    } bus_state_t;

endpackage

// >>> hdl/wb_reg_port.sv
`timescale 1ns/1ps
module wb_reg_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:2] adr_i,
    output logic ack_o,
    output logic rd_stb_o,
    output logic wr_stb_o,
    output fan_monitor_pkg::reg_byte_t idx_o
);
    import fan_monitor_pkg::*;

    bus_state_t state;

    // The access is carried out on the edge that raises ack, one cycle before the
    // master samples it, so the returned data is the value from before any read side effect.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= BUS_IDLE;
        end else begin
            case (state)
                BUS_IDLE: begin
                    if (cyc_i && stb_i) begin
                        state <= BUS_ANSWER;
                    end
                end
                BUS_ANSWER: state <= BUS_IDLE;
                default: state <= BUS_IDLE;
            endcase
        end
    end

    assign ack_o = (state == BUS_ANSWER);
    assign rd_stb_o = (state == BUS_IDLE) && cyc_i && stb_i && !we_i;
    assign wr_stb_o = (state == BUS_IDLE) && cyc_i && stb_i && we_i;
    assign idx_o = adr_i;

endmodule

// >>> hdl/overtemp_flag_unit.sv
`timescale 1ns/1ps
`include "fan_monitor_cfg.svh"
module overtemp_flag_unit (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic meas_done_i,
    input wire logic ch1_over_i,
    input wire logic ch2_over_i,
    input wire logic flags_read_i,
    input wire fan_monitor_pkg::reg_byte_t alert_mask_i,
    output fan_monitor_pkg::reg_byte_t flags_o,
    output logic alert_active_o,
    output logic ch1_set_o,
    output logic ch2_set_o
);
    import fan_monitor_pkg::*;

    // Faults are sampled only at the end of a measurement cycle.
    assign ch1_set_o = meas_done_i && ch1_over_i;
    assign ch2_set_o = meas_done_i && ch2_over_i;

    // A fault seen in the same cycle as the clearing read is kept, so no fault is lost.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_o <= `RST_OVERTEMP_FLAGS;
        end else begin
            if (flags_read_i) begin
                flags_o <= 8'h00;
            end
            if (ch1_set_o) begin
                flags_o[`BIT_CH1_FAULT] <= 1'b1;
            end
            if (ch2_set_o) begin
                flags_o[`BIT_CH2_FAULT] <= 1'b1;
            end
        end
    end

    // Alert follows unmasked flags; clearing on read releases it until re-set.
    assign alert_active_o = |(flags_o & ~alert_mask_i & `FLAGS_MASK);

endmodule

// >>> tb/overtemp_alert_status_mask_checker.sv
`timescale 1ns/1ps
`include "fan_monitor_cfg.svh"
module overtemp_alert_status_mask_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:2] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic meas_done_i,
    input wire logic ch1_over_i,
    input wire logic ch2_over_i,
    input wire logic overtemp_alert_out_n_o,
    input wire logic overtemp_alert_out_n_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // An access counts only while ack is low, so a strobe still held in the ack cycle is not taken twice.
    logic take;
    logic rd_any;
    logic rd_flags;
    logic mask_wr;
    assign take = cyc_i && stb_i && !ack_o;
    assign rd_any = take && !we_i && adr_i == `IDX_OVERTEMP_FLAGS;
    assign rd_flags = rd_any && !meas_done_i;
    assign mask_wr = take && we_i && adr_i == `IDX_OVERTEMP_ALERT_MASK;
    sequence s_fault1; meas_done_i && ch1_over_i ##2 rd_flags; endsequence
    sequence s_fault2; meas_done_i && ch2_over_i ##2 rd_flags; endsequence
    sequence s_two_reads; rd_flags ##1 (!meas_done_i) [*3] ##1 rd_flags; endsequence
    property p_answer; take |=> ack_o ##1 !ack_o; endproperty
    property p_ch1; s_fault1 |=> dat_o[7]; endproperty
    property p_ch2; s_fault2 |=> dat_o[6]; endproperty
    property p_clear; s_two_reads |=> dat_o[7:6] == 2'b00; endproperty
    property p_release; rd_flags |=> !overtemp_alert_out_n_oe_o; endproperty
    property p_rise;
        $rose(overtemp_alert_out_n_oe_o) |->
            $past(meas_done_i && (ch1_over_i || ch2_over_i)) || $past(mask_wr);
    endproperty
    property p_hold; overtemp_alert_out_n_oe_o && !rd_any && !mask_wr |=> overtemp_alert_out_n_oe_o;
    endproperty
    property p_reset;
        @(posedge clk_i) disable iff (1'b0) rst_i |=> !overtemp_alert_out_n_oe_o && !ack_o;
    endproperty
    property p_pull_low; overtemp_alert_out_n_oe_o |-> overtemp_alert_out_n_o == 1'b0; endproperty
    a_answer: assert property (p_answer) else $error("ack not one cycle after request");
    a_ch1: assert property (p_ch1) else $error("channel 1 flag missing");
    a_ch2: assert property (p_ch2) else $error("channel 2 flag missing");
    a_clear: assert property (p_clear) else $error("status not cleared by read");
    a_release: assert property (p_release) else $error("alert kept after read");
    a_rise: assert property (p_rise) else $error("alert rose without cause");
    a_hold: assert property (p_hold) else $error("alert dropped without read");
    a_reset: assert property (p_reset) else $error("alert or ack after reset");
    a_pull_low: assert property (p_pull_low) else $error("alert not pulled low");
endmodule
bind overtemp_alert_status_mask overtemp_alert_status_mask_checker checker_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .meas_done_i(meas_done_i),
    .ch1_over_i(ch1_over_i),
    .ch2_over_i(ch2_over_i),
    .overtemp_alert_out_n_o(overtemp_alert_out_n_o),
    .overtemp_alert_out_n_oe_o(overtemp_alert_out_n_oe_o)
);

// >>> tb/bus_host_model.sv
`timescale 1ns/1ps
`include "fan_monitor_cfg.svh"
module bus_host_model (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] rdata_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [9:2] adr_o,
    output logic [31:0] wdata_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        wdata_o = 32'h0;
    end
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= wr;
        adr_o <= idx;
        wdata_o <= {24'h0, wd};
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        rd = rdata_i[7:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        // Released lines flip so that a stale address or data is never mistaken for a live one.
        adr_o <= ~idx;
        wdata_o <= ~{24'h0, wd};
    endtask
    task automatic status_read(output logic [7:0] flags);
        logic [7:0] temp;
        xfer(1'b0, `IDX_OVERTEMP_FLAGS, 8'h00, flags);
        xfer(1'b0, 8'h00, 8'h00, temp);
    endtask
endmodule

// >>> tb/overtemp_alert_status_mask_test.sv
`timescale 1ns/1ps
`include "fan_monitor_cfg.svh"
module overtemp_alert_status_mask_test;
    import fan_monitor_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i;
    logic stb_i;
    logic we_i;
    logic [9:2] adr_i;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic ack_o;
    logic irq_o;
    logic meas_done_i = 1'b0;
    logic ch1_over_i = 1'b0;
    logic ch2_over_i = 1'b0;
    logic alert_n;
    logic alert_oe;
    pin_vec_t pin_out;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    reg_byte_t rd;
    reg_byte_t masks [5] = '{8'h80, 8'h40, 8'h80, 8'h40, 8'hc0};
    logic [2:0] cases [5] = '{3'b100, 3'b010, 3'b011, 3'b101, 3'b110};
    reg_byte_t ro_idx [4] = '{8'h0e, 8'hfd, 8'hfe, 8'hff};
    reg_byte_t ro_val [4] = '{8'h5a, 8'h11, 8'h22, 8'h33};
    overtemp_alert_status_mask dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .irq_o(irq_o), .meas_done_i(meas_done_i), .ch1_over_i(ch1_over_i),
        .ch2_over_i(ch2_over_i), .pwm2_duty_now_i(8'h5a),
        .overtemp_alert_out_n_o(alert_n), .overtemp_alert_out_n_oe_o(alert_oe),
        .pin_power_up_strap_i(5'h15), .general_pin_bit_i(5'h0a),
        .general_pin_bit_o(pin_out), .general_pin_bit_oe_o(), .ch1_fan_start_temp_o(),
        .ch2_fan_start_temp_o(), .fan_setup_o(), .duty_slew_rate_o(),
        .duty_step_size_o(), .pwm_freq_select_o()
    );
    bus_host_model host (
        .clk_i(clk_i), .ack_i(ack_o), .rdata_i(dat_o), .cyc_o(cyc_i), .stb_o(stb_i),
        .we_o(we_i), .adr_o(adr_i), .wdata_o(dat_i)
    );
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task close_out;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    task chk(input string name, input reg_byte_t exp, input reg_byte_t got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task rdchk(input reg_byte_t idx, input reg_byte_t exp);
        host.xfer(1'b0, idx, 8'h00, rd);
        chk($sformatf("index %h", idx), exp, rd);
    endtask
    task wr(input reg_byte_t idx, input reg_byte_t d);
        host.xfer(1'b1, idx, d, rd);
    endtask
    task meas(input logic c1, input logic c2);
        @(posedge clk_i);
        meas_done_i <= 1'b1;
        ch1_over_i <= c1;
        ch2_over_i <= c2;
        @(posedge clk_i);
        meas_done_i <= 1'b0;
    endtask
    // Levels are looked at mid-cycle, after the edge's own updates have landed.
    task lvl(input logic is_irq, input logic exp);
        @(negedge clk_i);
        chk(is_irq ? "irq" : "alert", {7'h0, exp}, {7'h0, is_irq ? irq_o : alert_oe});
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(`IDX_OVERTEMP_ALERT_MASK, 8'h00);
        rdchk(`IDX_OVERTEMP_FLAGS, 8'h00);
        rdchk(`IDX_PIN_LEVEL, 8'h15);
        rdchk(`IDX_DUTY_STEP_SIZE, 8'h55);
        rdchk(`IDX_DUTY_SLEW_RATE, 8'hb4);
        rdchk(`IDX_PWM_FREQ_SELECT, 8'h40);
        chk("pin out", 8'h15, {3'h0, pin_out});
        wr(`IDX_PIN_DIRECTION, 8'h1f);
        rdchk(`IDX_PIN_LEVEL, 8'h0a);
        meas(1'b1, 1'b0);
        lvl(1'b0, 1'b1);
        rdchk(`IDX_OVERTEMP_FLAGS, 8'h80);
        lvl(1'b0, 1'b0);
        rdchk(`IDX_OVERTEMP_FLAGS, 8'h00);
        meas(1'b0, 1'b1);
        rdchk(`IDX_OVERTEMP_FLAGS, 8'h40);
        meas(1'b0, 1'b1);
        lvl(1'b0, 1'b1);
        wr(`IDX_OVERTEMP_FLAGS, 8'h00);
        lvl(1'b0, 1'b1);
        host.status_read(rd);
        chk("flags", 8'h40, rd);
        for (int i = 0; i < 5; i++) begin
            wr(`IDX_OVERTEMP_ALERT_MASK, masks[i]);
            meas(cases[i][2], cases[i][1]);
            lvl(1'b0, cases[i][0]);
            host.status_read(rd);
            chk("flags", {cases[i][2:1], 6'h00}, rd);
        end
        wr(`IDX_OVERTEMP_ALERT_MASK, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(ro_idx[i], 8'h00);
            rdchk(ro_idx[i], ro_val[i]);
        end
        wr(`IDX_CH1_FAN_START_TEMP, 8'ha5);
        rdchk(`IDX_CH1_FAN_START_TEMP, 8'ha5);
        wr(8'h30, 8'hff);
        rdchk(8'h30, 8'h00);
        wr(`IDX_EVENT_ENABLE, 8'h07);
        meas(1'b1, 1'b0);
        lvl(1'b1, 1'b1);
        wr(`IDX_EVENT_ENABLE, 8'h00);
        lvl(1'b1, 1'b0);
        wr(`IDX_EVENT_ENABLE, 8'h07);
        lvl(1'b1, 1'b1);
        wr(`IDX_EVENT_STATUS, 8'h07);
        lvl(1'b1, 1'b0);
        rdchk(`IDX_EVENT_STATUS, 8'h00);
        close_out();
    end
endmodule
